// file: bsp_spi.sv
/*
  Clock-stop (SPI) engine of a buffered serial port with pin GPIO option.
  Master: divides ref_clk into the bit clock and drives slave-select.
  Slave: follows an external bit clock and select through synchronisers.
  Assumes cfg comes from logic on ref_clk and is steady during a frame.
*/
`timescale 1ns/1ps
module bsp_spi
  import bsp_pkg::*;
#(
  parameter int DIV_W = BSP_DIV_W,
  parameter int WORD_W = BSP_WORD_W,
  parameter int FIFO_DEPTH = BSP_FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire bsp_cfg_t cfg,
  input wire logic [WORD_W-1:0] tx_word,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [WORD_W-1:0] rx_word,
  output logic rx_valid,
  output logic busy,
  output logic rx_frame_active,
  input wire bsp_pins_t port_pin_i,
  output bsp_pins_t port_pin_o,
  output bsp_pins_t port_pin_oe,
  input wire bsp_pins_t port_pin_as_gpio,
  input wire bsp_pins_t gpio_drive,
  input wire bsp_pins_t gpio_out,
  output bsp_pins_t gpio_in
);

  localparam int BW = $clog2(WORD_W + 1);
  localparam logic [BW-1:0] BITS_ALL = BW'(WORD_W);

  typedef struct packed {
    bsp_state_t st;
    logic [DIV_W-1:0] cnt;
    logic [BW-1:0] bit_cnt;
    logic [WORD_W-1:0] tx_sh;
    logic [WORD_W-1:0] rx_sh;
    logic fs_int;
    logic clk_int;
    logic dat_o;
    logic dat_oe;
    bsp_pins_t sync1;
    bsp_pins_t sync2;
    bsp_pins_t sync3;
    bsp_pins_t pin_o;
    bsp_pins_t pin_oe;
    bsp_pins_t gpio_in;
    logic [WORD_W-1:0] rx_word;
    logic rx_valid;
    logic busy;
    logic rx_frame_active;
  } bsp_st_t;

  bsp_st_t r;
  bsp_st_t n;

  logic fifo_vld;
  logic fifo_pop;
  logic [WORD_W-1:0] fifo_data;

  // ----------------------------------------------------------------------
  // Transmit buffer; a full buffer stalls the producer through tx_ready
  // ----------------------------------------------------------------------
  bsp_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_word),
    .out_valid(fifo_vld),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // ----------------------------------------------------------------------
  // Bit clock phase lengths
  // ----------------------------------------------------------------------
  // A divide value of zero cannot give half-cycle phases, so it runs as 1
  logic [DIV_W:0] dv;
  logic [DIV_W:0] per_len;
  logic [DIV_W:0] low_len;
  logic [DIV_W:0] high_len;
  logic [DIV_W:0] lead_len;
  logic cstop_en;
  logic mode11;
  logic master;

  always_comb begin
    dv = (cfg.srg_divide_value == '0) ? (DIV_W + 1)'(1) : {1'b0, cfg.srg_divide_value};
    per_len = dv + 1'b1;
    low_len = dv[0] ? (per_len >> 1) : (dv >> 1);
    high_len = per_len - low_len;
    cstop_en = cfg.clock_stop_mode_field[BSP_CSTP_EN_BIT];
    mode11 = cfg.clock_stop_mode_field[BSP_CSTP_PHASE_BIT];
    lead_len = mode11 ? per_len : low_len;
    master = cfg.tx_clock_direction;
  end

  // ----------------------------------------------------------------------
  // Edge events
  // ----------------------------------------------------------------------
  logic s_clk;
  logic s_clk_d;
  logic s_sel;
  logic s_sel_d;
  logic ev_start;
  logic ev_rise;
  logic ev_fall;

  always_comb begin
    // Slave inputs come from the second and third stages only
    s_clk = r.sync2.tx_bit_clock_pin ^ cfg.tx_clock_polarity;
    s_clk_d = r.sync3.tx_bit_clock_pin ^ cfg.tx_clock_polarity;
    s_sel = r.sync2.tx_frame_sync_pin ^ cfg.tx_frame_polarity;
    s_sel_d = r.sync3.tx_frame_sync_pin ^ cfg.tx_frame_polarity;
    if (!cstop_en) begin
      ev_start = 1'b0;
      ev_rise = 1'b0;
      ev_fall = 1'b0;
    end else if (master) begin
      ev_start = (r.st == BSP_IDLE) && fifo_vld;
      ev_rise = ((r.st == BSP_LEAD) || (r.st == BSP_LOW)) && (r.cnt == '0);
      ev_fall = (r.st == BSP_HIGH) && (r.cnt == '0);
    end else begin
      // Edges only count while selected; the slow sampling limits clock rate
      ev_start = s_sel && !s_sel_d;
      ev_rise = s_sel && s_sel_d && s_clk && !s_clk_d;
      ev_fall = s_sel && s_sel_d && !s_clk && s_clk_d;
    end
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  logic do_launch;
  logic do_sample;
  logic [WORD_W-1:0] rx_next;
  bsp_pins_t po;
  bsp_pins_t poe;

  always_comb begin
    n = r;
    n.rx_valid = 1'b0;
    n.sync1 = port_pin_i;
    n.sync2 = r.sync1;
    n.sync3 = r.sync2;
    n.gpio_in = r.sync2 & port_pin_as_gpio & BSP_GPIO_IN_OK;
    n.rx_frame_active = r.sync2.rx_frame_sync_pin ^ cfg.rx_frame_polarity;
    fifo_pop = 1'b0;
    rx_next = {r.rx_sh[WORD_W-2:0], r.sync2.rx_data_pin};
    do_launch = (mode11 ? ev_fall : ev_rise) && (r.bit_cnt < BITS_ALL);
    do_sample = (mode11 ? ev_rise : ev_fall) && (r.bit_cnt < BITS_ALL);

    if (ev_start) begin
      // Empty buffer in slave mode shifts out zeros rather than stale data
      fifo_pop = fifo_vld;
      n.tx_sh = fifo_vld ? fifo_data : '0;
      n.bit_cnt = '0;
      n.busy = 1'b1;
      n.fs_int = master;
      if (mode11) begin
        n.dat_o = n.tx_sh[WORD_W-1];
        n.tx_sh = {n.tx_sh[WORD_W-2:0], 1'b0};
        n.dat_oe = 1'b1;
      end
    end
    if (do_launch) begin
      n.dat_o = r.tx_sh[WORD_W-1];
      n.tx_sh = {r.tx_sh[WORD_W-2:0], 1'b0};
      n.dat_oe = 1'b1;
    end
    if (do_sample) begin
      n.rx_sh = rx_next;
      n.bit_cnt = r.bit_cnt + 1'b1;
      if (r.bit_cnt == BITS_ALL - 1'b1) begin
        n.rx_word = rx_next;
        n.rx_valid = 1'b1;
      end
    end

    if (!cstop_en) begin
      n.st = BSP_IDLE;
      n.fs_int = 1'b0;
      n.clk_int = 1'b0;
      n.dat_oe = 1'b0;
      n.busy = 1'b0;
    end else if (master) begin
      unique case (r.st)
        BSP_IDLE: begin
          if (ev_start) begin
            n.st = BSP_LEAD;
            n.cnt = DIV_W'(lead_len - 1'b1);
          end
        end
        BSP_LEAD, BSP_LOW: begin
          if (r.cnt == '0) begin
            n.clk_int = 1'b1;
            n.st = BSP_HIGH;
            n.cnt = DIV_W'(high_len - 1'b1);
          end else begin
            n.cnt = r.cnt - 1'b1;
          end
        end
        BSP_HIGH: begin
          if (r.cnt != '0) begin
            n.cnt = r.cnt - 1'b1;
          end else if (n.bit_cnt == BITS_ALL) begin
            // Select and data release together in the same cycle as the last falling edge
            n.clk_int = 1'b0;
            n.st = BSP_IDLE;
            n.fs_int = 1'b0;
            n.dat_oe = 1'b0;
            n.busy = 1'b0;
          end else begin
            n.clk_int = 1'b0;
            n.st = BSP_LOW;
            n.cnt = DIV_W'(low_len - 1'b1);
          end
        end
      endcase
    end else begin
      n.st = BSP_IDLE;
      n.fs_int = 1'b0;
      n.clk_int = 1'b0;
      if (!s_sel) begin
        n.dat_oe = 1'b0;
        n.busy = 1'b0;
      end
    end

    // Pin drivers, then GPIO override per pin
    po.tx_bit_clock_pin = n.clk_int ^ cfg.tx_clock_polarity;
    po.rx_bit_clock_pin = n.clk_int ^ cfg.rx_clock_polarity;
    po.tx_frame_sync_pin = n.fs_int ^ cfg.tx_frame_polarity;
    po.rx_frame_sync_pin = n.fs_int ^ cfg.rx_frame_polarity;
    po.tx_data_pin = n.dat_o;
    po.rx_data_pin = 1'b0;
    poe.tx_bit_clock_pin = cfg.tx_clock_direction;
    poe.rx_bit_clock_pin = cfg.rx_clock_direction;
    poe.tx_frame_sync_pin = cfg.tx_frame_direction;
    poe.rx_frame_sync_pin = cfg.rx_frame_direction;
    poe.tx_data_pin = n.dat_oe && cstop_en;
    poe.rx_data_pin = 1'b0;
    n.pin_o = (po & ~port_pin_as_gpio) | (gpio_out & port_pin_as_gpio);
    n.pin_oe = (poe & ~port_pin_as_gpio) | (gpio_drive & port_pin_as_gpio & BSP_GPIO_OUT_OK);
  end

  // Single clock for all port logic
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '{st: BSP_IDLE, cnt: '0, bit_cnt: '0, tx_sh: '0, rx_sh: '0, fs_int: 1'b0,
             clk_int: 1'b0, dat_o: 1'b0, dat_oe: 1'b0, sync1: BSP_PINS_RST,
             sync2: BSP_PINS_RST, sync3: BSP_PINS_RST, pin_o: BSP_PINS_RST,
             pin_oe: BSP_PINS_RST, gpio_in: BSP_PINS_RST, rx_word: '0,
             rx_valid: 1'b0, busy: 1'b0, rx_frame_active: 1'b0};
    end else begin
      r <= n;
    end
  end

  assign rx_word = r.rx_word;
  assign rx_valid = r.rx_valid;
  assign busy = r.busy;
  assign rx_frame_active = r.rx_frame_active;
  assign port_pin_o = r.pin_o;
  assign port_pin_oe = r.pin_oe;
  assign gpio_in = r.gpio_in;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [DIV_W+1:0] since_rise_r;
  logic [DIV_W+1:0] since_fall_r;
  logic [DIV_W+1:0] since_start_r;
  logic m_rise;
  logic m_fall;
  logic m_act;

  assign m_act = cstop_en && master;
  assign m_rise = m_act && ev_rise;
  assign m_fall = m_act && ev_fall;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      since_rise_r <= '0;
      since_fall_r <= '0;
      since_start_r <= '0;
    end else begin
      since_rise_r <= m_rise ? (DIV_W + 2)'(1) : since_rise_r + 1'b1;
      since_fall_r <= m_fall ? (DIV_W + 2)'(1) : since_fall_r + 1'b1;
      since_start_r <= (m_act && ev_start) ? (DIV_W + 2)'(1) : since_start_r + 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  a_bit_period: assert property (m_rise && r.st == BSP_LOW |->
    since_rise_r == {1'b0, per_len})
    else $error("bit clock period wrong");

  a_low_phase: assert property (m_rise && r.st == BSP_LOW |->
    since_fall_r == {1'b0, low_len})
    else $error("bit clock low phase wrong");

  a_high_phase: assert property (m_fall |-> since_rise_r == {1'b0, high_len})
    else $error("bit clock high phase wrong");

  a_lead_time: assert property (m_rise && r.st == BSP_LEAD |->
    since_start_r == {1'b0, lead_len})
    else $error("select to first rise wrong");

  a_select_first: assert property ($rose(r.clk_int) |-> r.fs_int && $past(r.fs_int))
    else $error("clock rose without select");

  a_select_pin: assert property (m_act && !port_pin_as_gpio.tx_frame_sync_pin &&
    cfg.tx_frame_polarity && $rose(r.fs_int) |-> !port_pin_o.tx_frame_sync_pin ##1 r.busy)
    else $error("select pin not active low");

  a_slave_select: assert property (cstop_en && !master && cfg.tx_frame_polarity &&
    $fell(r.sync2.tx_frame_sync_pin) |=> r.busy)
    else $error("slave select not recognised");

  a_launch_rise: assert property (m_rise && !mode11 && r.bit_cnt < BITS_ALL &&
    !port_pin_as_gpio.tx_data_pin |=> port_pin_o.tx_data_pin == $past(r.tx_sh[WORD_W-1]))
    else $error("mode 10b launch wrong");

  a_launch_fall: assert property (m_fall && mode11 && r.bit_cnt < BITS_ALL &&
    !port_pin_as_gpio.tx_data_pin |=> port_pin_o.tx_data_pin == $past(r.tx_sh[WORD_W-1]))
    else $error("mode 11b launch wrong");

  a_no_stray_data: assert property (port_pin_oe.tx_data_pin &&
    !$past(port_pin_as_gpio.tx_data_pin) |-> r.busy)
    else $error("data driven outside frame");

  a_gpio_drive: assert property (port_pin_as_gpio.tx_data_pin && gpio_drive.tx_data_pin
    |=> port_pin_oe.tx_data_pin && port_pin_o.tx_data_pin == $past(gpio_out.tx_data_pin))
    else $error("gpio output not updated");

  a_gpio_sample: assert property ($past(port_pin_as_gpio.rx_data_pin) |->
    gpio_in.rx_data_pin == $past(port_pin_i.rx_data_pin, 3))
    else $error("gpio input not sampled");

endmodule : bsp_spi

// file: bsp_pkg.sv
/*
  Shared constants and types of the clock-stop serial port: pin bundle,
  configuration word, transfer states, field widths and reset values.
  Assumes one clock domain (the slow peripheral clock) for the whole block.
*/
package bsp_pkg;

  // ----------------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------------
  localparam int BSP_DIV_W = 8;
  localparam int BSP_WORD_W = 8;
  localparam int BSP_FIFO_DEPTH = 4;
  localparam int BSP_CLK_PERIOD_NS = 10;

  // ----------------------------------------------------------------------
  // Clock-stop mode encodings
  // ----------------------------------------------------------------------
  localparam int BSP_CSTP_EN_BIT = 1;
  localparam int BSP_CSTP_PHASE_BIT = 0;
  localparam logic [1:0] BSP_CSTP_NO_DELAY = 2'h2;
  localparam logic [1:0] BSP_CSTP_DELAY = 2'h3;

  // ----------------------------------------------------------------------
  // Pin bundle: one bit per port pin, most significant first
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic rx_bit_clock_pin;
    logic rx_frame_sync_pin;
    logic rx_data_pin;
    logic tx_bit_clock_pin;
    logic tx_frame_sync_pin;
    logic tx_data_pin;
  } bsp_pins_t;

  // Receive data cannot drive, transmit data cannot be read as GPIO
  localparam bsp_pins_t BSP_GPIO_IN_OK = 6'h3E;
  localparam bsp_pins_t BSP_GPIO_OUT_OK = 6'h37;
  localparam bsp_pins_t BSP_PINS_RST = 6'h00;

  // ----------------------------------------------------------------------
  // Configuration word, held steady by software while a frame runs
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [BSP_DIV_W-1:0] srg_divide_value;
    logic [1:0] clock_stop_mode_field;
    logic rx_clock_polarity;
    logic tx_clock_polarity;
    logic rx_frame_polarity;
    logic tx_frame_polarity;
    logic rx_clock_direction;
    logic tx_clock_direction;
    logic rx_frame_direction;
    logic tx_frame_direction;
  } bsp_cfg_t;

  // ----------------------------------------------------------------------
  // Master sequencer, Gray coded along idle-lead-high-low
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    BSP_IDLE = 2'b00,
    BSP_LEAD = 2'b01,
    BSP_HIGH = 2'b11,
    BSP_LOW = 2'b10
  } bsp_state_t;

endpackage : bsp_pkg

// file: bsp_fifo.sv
/*
  Small word FIFO with valid/ready on both sides; flags and storage are
  flip-flops, so the drain side sees registered data and flags.
  Assumes both sides run on the same clock.
*/
`timescale 1ns/1ps
module bsp_fifo
  import bsp_pkg::*;
#(
  parameter int WIDTH = BSP_WORD_W,
  parameter int DEPTH = BSP_FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic rdy;
    logic vld;
  } bsp_fifo_st_t;

  bsp_fifo_st_t r;
  bsp_fifo_st_t n;
  logic push;
  logic pop;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    n = r;
    push = in_valid && r.rdy;
    pop = out_ready && r.vld;
    if (push) begin
      n.mem[r.wp] = in_data;
      n.wp = (r.wp == AW'(DEPTH - 1)) ? '0 : r.wp + 1'b1;
    end
    if (pop) begin
      n.rp = (r.rp == AW'(DEPTH - 1)) ? '0 : r.rp + 1'b1;
    end
    n.cnt = r.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    // Flags follow the next count so both stay pure flip-flops
    n.rdy = (n.cnt != (AW + 1)'(DEPTH));
    n.vld = (n.cnt != '0);
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '{mem: '0, wp: '0, rp: '0, cnt: '0, rdy: 1'b1, vld: 1'b0};
    end else begin
      r <= n;
    end
  end

  assign in_ready = r.rdy;
  assign out_valid = r.vld;
  assign out_data = r.mem[r.rp];

endmodule : bsp_fifo

// file: bsp_spi_partner.sv
/*
  Far-side model of the clock-stop port: an SPI slave when the block is
  master, and a task-driven SPI master when the block is slave.
  Assumes frame polarity 1 (active-low select) and the one ref_clk domain.
*/
`timescale 1ns/1ps
module bsp_spi_partner
  import bsp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic dev_master,
  input wire logic cpol,
  input wire logic mode11,
  input wire logic [7:0] reply,
  input wire bsp_pins_t dev_o,
  input wire bsp_pins_t dev_oe,
  input wire bsp_pins_t gp_en,
  input wire bsp_pins_t gp_val,
  output bsp_pins_t pins,
  output logic [7:0] cap,
  output int nbits
);
  // ----------------------------------------------------------------------
  // Pin resolution
  // ----------------------------------------------------------------------
  bsp_pins_t m_drv = BSP_PINS_RST;
  bsp_pins_t m_en = BSP_PINS_RST;
  logic flt = 1'b0;
  logic txd_q = 1'b0;
  logic sel_q = 1'b0;
  logic [7:0] sh = 8'h00;
  logic sclk;
  logic sel;

  // Released lines toggle so a stale level is never taken for data; both
  // select lines have pull-ups, so a released bus never selects anyone
  always @(posedge ref_clk) flt <= ~flt;
  // Data is taken as it stood before the edge, as a real slave would
  always @(negedge ref_clk) begin
    txd_q <= pins.tx_data_pin;
    sel_q <= sel;
  end
  assign pins = bsp_pins_t'((dev_oe & dev_o) | (~dev_oe & gp_en & gp_val)
    | (~dev_oe & ~gp_en & ((m_en & m_drv) | (~m_en & ({6{flt}} | 6'h12)))));
  assign sclk = pins.tx_bit_clock_pin ^ cpol;
  assign sel = dev_master & ~pins.tx_frame_sync_pin;

  // ----------------------------------------------------------------------
  // Slave role
  // ----------------------------------------------------------------------
  initial begin
    cap = 8'h00;
    nbits = 0;
  end
  task automatic take();
    sh = {sh[6:0], txd_q};
    nbits++;
    if (nbits == 8) cap = sh;
  endtask : take
  always @(posedge sel) begin
    nbits = 0;
    m_en.rx_data_pin = 1'b1;
    m_drv.rx_data_pin = reply[7];
  end
  always @(negedge sel) m_en.rx_data_pin = 1'b0;
  always @(posedge sclk) if (sel_q) begin
    if (mode11) take();
    else if (nbits < 8) m_drv.rx_data_pin = reply[7-nbits];
  end
  always @(negedge sclk) if (sel_q) begin
    if (!mode11) take();
    else if (nbits < 8) m_drv.rx_data_pin = reply[7-nbits];
  end

  // ----------------------------------------------------------------------
  // Master role: clock half period of half ref_clk cycles
  // ----------------------------------------------------------------------
  task automatic ext_master(input logic [7:0] mosi, input int half, output logic [7:0] miso);
    logic [7:0] got;
    got = 8'h00;
    @(negedge ref_clk);
    m_drv = bsp_pins_t'(6'h02);
    m_drv.tx_bit_clock_pin = cpol;
    m_drv.rx_data_pin = mosi[7];
    m_en = bsp_pins_t'(6'h0E);
    repeat (half) @(negedge ref_clk);
    m_drv.tx_frame_sync_pin = 1'b0;
    repeat (2 * half) @(negedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      m_drv.tx_bit_clock_pin = ~cpol;
      if (mode11) got = {got[6:0], pins.tx_data_pin};
      else m_drv.rx_data_pin = mosi[7-i];
      repeat (half) @(negedge ref_clk);
      m_drv.tx_bit_clock_pin = cpol;
      if (!mode11) got = {got[6:0], pins.tx_data_pin};
      else if (i < 7) m_drv.rx_data_pin = mosi[6-i];
      repeat (half) @(negedge ref_clk);
    end
    m_drv.tx_frame_sync_pin = 1'b1;
    repeat (half) @(negedge ref_clk);
    m_en = BSP_PINS_RST;
    miso = got;
  endtask : ext_master
endmodule : bsp_spi_partner

// file: test_bsp_spi.sv
/*
  Self-checking bench of the clock-stop serial port: reset, GPIO, FIFO with
  slave transfers, master clock timing per divide value, back-to-back frames.
  Assumes bsp_spi_partner as far side; inputs change on the falling edge.
*/
`timescale 1ns/1ps
module test_bsp_spi
  import bsp_pkg::*;
;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  bsp_cfg_t cfg = '0;
  logic [7:0] tx_word = 8'h00;
  logic tx_valid = 1'b0;
  logic tx_ready, rx_valid, busy, rx_frame_active;
  logic [7:0] rx_word, reply = 8'h00, cap, last_rx = 8'h00;
  bsp_pins_t pins, p_o, p_oe, gpio_in;
  bsp_pins_t gpio_mode = '0, gpio_drive = '0, gpio_out = '0, gp_en = '0, gp_val = '0;
  int num_errors = 0, checks = 0, rx_cnt = 0, nbits, cyc = 0, t_sel = 0, nr = 0, nf = 0;
  int rise [16];
  int fall [16];
  logic sel_q = 1'b0, sclk_q = 1'b0;
  logic [5:0] pats [2] = '{6'h2A, 6'h15};
  logic [7:0] dv_t [6] = '{8'h01, 8'h02, 8'h05, 8'h06, 8'h07, 8'h00};
  logic m11_t [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
  logic pol_t [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

  initial begin
    forever #(BSP_CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
  end

  bsp_spi i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .cfg(cfg), .tx_word(tx_word),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_word(rx_word), .rx_valid(rx_valid),
    .busy(busy), .rx_frame_active(rx_frame_active), .port_pin_i(pins), .port_pin_o(p_o),
    .port_pin_oe(p_oe), .port_pin_as_gpio(gpio_mode), .gpio_drive(gpio_drive),
    .gpio_out(gpio_out), .gpio_in(gpio_in));
  bsp_spi_partner i_partner (.ref_clk(ref_clk), .dev_master(cfg.tx_clock_direction),
    .cpol(cfg.tx_clock_polarity), .mode11(cfg.clock_stop_mode_field[BSP_CSTP_PHASE_BIT]),
    .reply(reply), .dev_o(p_o), .dev_oe(p_oe), .gp_en(gp_en), .gp_val(gp_val),
    .pins(pins), .cap(cap), .nbits(nbits));

  // ----------------------------------------------------------------------
  // Edge monitor, in ref_clk cycles as seen mid-cycle
  // ----------------------------------------------------------------------
  always @(negedge ref_clk) begin
    if (rx_valid === 1'b1) begin
      rx_cnt++;
      last_rx = rx_word;
    end
    cyc++;
    if (~pins.tx_frame_sync_pin && !sel_q) t_sel = cyc;
    if ((pins.tx_bit_clock_pin ^ cfg.tx_clock_polarity) && !sclk_q && nr < 16) begin
      rise[nr] = cyc;
      nr++;
    end
    if (!(pins.tx_bit_clock_pin ^ cfg.tx_clock_polarity) && sclk_q && nf < 16) begin
      fall[nf] = cyc;
      nf++;
    end
    sel_q = ~pins.tx_frame_sync_pin;
    sclk_q = pins.tx_bit_clock_pin ^ cfg.tx_clock_polarity;
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  task automatic hang();
    num_errors++;
    $display("CHECK FAILED wait expected event seen timeout");
    end_sim();
  endtask : hang
  task automatic set_cfg(input logic [7:0] d, input logic [1:0] m, input logic pol,
    input logic mst);
    @(negedge ref_clk);
    cfg = '{d, m, pol, pol, 1'b1, 1'b1, 1'b0, mst, 1'b0, mst};
    repeat (4) @(negedge ref_clk);
  endtask : set_cfg
  // Valid is held until ready is seen, so a refused word is never lost
  task automatic push(input logic [7:0] w);
    int n;
    n = 0;
    @(negedge ref_clk);
    tx_word = w;
    tx_valid = 1'b1;
    while (tx_ready !== 1'b1 && n < 2000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 2000) hang();
    @(negedge ref_clk);
    tx_valid = 1'b0;
  endtask : push
  task automatic wait_rx(input int target);
    int n;
    n = 0;
    while (rx_cnt < target && n < 2000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 2000) hang();
  endtask : wait_rx

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    int n0, d, per, lo, hi;
    logic [7:0] miso;
    repeat (2) @(negedge ref_clk);
    chk("ready in reset", 32'(tx_ready), 32'h1);
    chk("oe in reset", 32'(p_oe), 32'h0);
    arst_n = 1'b1;
    $display("test reset done");
    set_cfg(8'h01, 2'h0, 1'b0, 1'b0);
    gpio_mode = bsp_pins_t'(6'h3F);
    for (int j = 0; j < 2; j++) begin
      gp_en = '0;
      gpio_drive = BSP_GPIO_OUT_OK;
      gpio_out = bsp_pins_t'(pats[j]);
      repeat (3) @(negedge ref_clk);
      chk("gpio oe", 32'(p_oe), 32'(BSP_GPIO_OUT_OK));
      chk("gpio out", 32'(p_o & BSP_GPIO_OUT_OK), 32'(pats[j] & BSP_GPIO_OUT_OK));
      gpio_drive = '0;
      gp_en = bsp_pins_t'(6'h3F);
      gp_val = bsp_pins_t'(pats[j]);
      repeat (5) @(negedge ref_clk);
      chk("gpio in", 32'(gpio_in), 32'(pats[j] & BSP_GPIO_IN_OK));
      chk("frame active", 32'(rx_frame_active), 32'(!pats[j][4]));
    end
    gpio_mode = '0;
    gp_en = '0;
    $display("test gpio done");
    set_cfg(8'h01, BSP_CSTP_NO_DELAY, 1'b0, 1'b0);
    for (int i = 0; i < 4; i++) push(8'hA0 | 8'(i));
    @(negedge ref_clk);
    tx_word = 8'hA4;
    tx_valid = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk("fifo full", 32'(tx_ready), 32'h0);
    // Withdraw the refused word; it is offered again once a frame frees a slot
    tx_valid = 1'b0;
    for (int i = 0; i < 6; i++) begin
      set_cfg(8'h01, (i % 2 == 1) ? BSP_CSTP_DELAY : BSP_CSTP_NO_DELAY, 1'b0, 1'b0);
      n0 = rx_cnt;
      i_partner.ext_master(8'h3C ^ 8'(i * 7), 8, miso);
      wait_rx(n0 + 1);
      chk("slave rx", 32'(last_rx), 32'(8'h3C ^ 8'(i * 7)));
      chk("slave tx", 32'(miso), (i < 5) ? 32'(8'hA0 | 8'(i)) : 32'h0);
      chk("slave oe", 32'(p_oe), 32'h0);
      if (i == 0) push(8'hA4);
    end
    $display("test slave fifo done");
    for (int k = 0; k < 6; k++) begin
      set_cfg(dv_t[k], {1'b1, m11_t[k]}, pol_t[k], 1'b1);
      reply = 8'h96 ^ 8'(k);
      nr = 0;
      nf = 0;
      n0 = rx_cnt;
      push(8'h69 + 8'(k));
      wait_rx(n0 + 1);
      repeat (6) @(negedge ref_clk);
      d = (dv_t[k] == 8'h00) ? 1 : int'(dv_t[k]);
      per = d + 1;
      lo = (d % 2 == 1) ? (d + 1) / 2 : d / 2;
      hi = per - lo;
      chk("rises", 32'(nr), 32'h8);
      chk("lead", 32'(rise[0] - t_sel), m11_t[k] ? 32'(per) : 32'(lo));
      chk("period", 32'(rise[1] - rise[0]), 32'(per));
      chk("high", 32'(fall[0] - rise[0]), 32'(hi));
      chk("low", 32'(rise[1] - fall[0]), 32'(lo));
      chk("slave got", 32'(cap), 32'(8'h69 + 8'(k)));
      chk("bit count", 32'(nbits), 32'h8);
      // Sampling lags two cycles: the phase before the sample must be 3 or more
      if ((m11_t[k] ? lo : hi) >= 3) chk("master rx", 32'(last_rx), 32'(reply));
      chk("idle pins", 32'({pins.tx_bit_clock_pin, pins.tx_frame_sync_pin,
        p_oe.tx_data_pin}), 32'({pol_t[k], 2'b10}));
      chk("dir oe", 32'({p_oe.rx_bit_clock_pin, p_oe.rx_frame_sync_pin,
        p_oe.tx_bit_clock_pin, p_oe.tx_frame_sync_pin}), 32'h3);
    end
    $display("test master timing done");
    set_cfg(8'h03, BSP_CSTP_NO_DELAY, 1'b0, 1'b1);
    n0 = rx_cnt;
    for (int i = 0; i < 3; i++) push(8'h11 << i);
    wait_rx(n0 + 3);
    repeat (4) @(negedge ref_clk);
    chk("last of burst", 32'(cap), 32'h44);
    chk("burst idle", 32'(busy), 32'h0);
    $display("test master burst done");
    end_sim();
  end
endmodule : test_bsp_spi
